// ### design/gp_timer.sv
/*
 * General purpose 32-bit up/down timer with prescaler, time format,
 * capture, postscaler and a plain register port.
 * Assumes clock source levels and event inputs synchronous to clk_sys.
 */
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "gp_timer_consts.svh"

module gp_timer
#(
    parameter int CNT_W = 32,
    parameter int NUM_EVT = 17
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [31:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [31:0] rdData_ff,
    input wire logic oscClk,
    input wire logic coreClk,
    input wire logic periphClk,
    input wire logic generalInputPin,
    input wire logic lowPower,
    input wire logic [NUM_EVT-1:0] irqSource,
    output logic irq_ff
);

    generate
        if (CNT_W != 32 || NUM_EVT < 1 || NUM_EVT > 32)
        begin : g_bad
            $error("gp_timer: unsupported parameters");
        end
    endgenerate

    gp_timer_pkg::word_type reload_ff;
    gp_timer_pkg::word_type count_ff;
    gp_timer_pkg::word_type capture_ff;
    gp_timer_pkg::word_type ctrl_ff;
    logic [`STAT_W-1:0] status_ff;
    logic [`STAT_W-1:0] mask_ff;
    logic [3:0] srcPrev_ff;
    logic [14:0] presCnt_ff;
    logic [7:0] postCnt_ff;
    logic [NUM_EVT-1:0] evtPrev_ff;

    logic wrReload;
    logic wrCtrl;
    logic wrClear;
    logic wrMask;
    logic rdStatus;
    logic srcRise;
    logic srcTick;
    logic preTick;
    logic [14:0] preMask;
    logic [32:0] stepVal;
    logic wrapEvt;
    logic postHit;
    logic capRise;
    logic [3:0] srcNow;
    logic [2:0] srcSel;
    logic [4:0] evtSel;
    logic [1:0] fmtSel;
    logic [NUM_EVT-1:0] evtRise;
    logic [`STAT_W-1:0] statSet;

    // register port decode
    assign wrReload = wrEn && addr == `ADDR_RELOAD;
    assign wrCtrl = wrEn && addr == `ADDR_CONTROL;
    assign wrClear = wrEn && addr == `ADDR_CLEAR;
    assign wrMask = wrEn && addr == `ADDR_MASK;
    assign rdStatus = rdEn && addr == `ADDR_STATUS;

    // control fields
    assign srcSel = ctrl_ff[`SRC_HI:`SRC_LO];
    assign evtSel = ctrl_ff[`EVT_HI:`EVT_LO];
    assign fmtSel = ctrl_ff[`FMT_HI:`FMT_LO];

    // source clock edge detection, low power gating
    assign srcNow = {generalInputPin, periphClk, coreClk, oscClk};
    always_comb
    begin
        srcRise = 1'b0;
        if (srcSel <= 3'(gp_timer_pkg::SRC_PIN))
        begin
            srcRise = srcNow[srcSel[1:0]] && !srcPrev_ff[srcSel[1:0]];
        end
    end
    assign srcTick = ctrl_ff[`BIT_ENABLE] && srcRise
        && (!lowPower
            || srcSel == 3'(gp_timer_pkg::SRC_OSC)
            || srcSel == 3'(gp_timer_pkg::SRC_PIN));

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            srcPrev_ff <= 4'h0;
        end
        else
        begin
            srcPrev_ff <= srcNow;
        end
    end

    // prescaler: tick when the masked low bits are all ones
    always_comb
    begin
        case (ctrl_ff[`PRE_HI:`PRE_LO])
            `PRE_DIV16: preMask = `MASK_DIV16;
            `PRE_DIV256: preMask = `MASK_DIV256;
            `PRE_DIV32K: preMask = `MASK_DIV32K;
            default: preMask = 15'h0000;
        endcase
    end
    assign preTick = srcTick && ((presCnt_ff & preMask) == preMask);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            presCnt_ff <= 15'h0000;
        end
        else if (wrClear || wrCtrl)
        begin
            presCnt_ff <= 15'h0000;
        end
        else if (srcTick)
        begin
            presCnt_ff <= presCnt_ff + 15'h0001;
        end
    end

    // one count step in binary or time format; msb flags the wrap
    function automatic logic [32:0] stepFn(input logic [31:0] v,
        input logic up, input logic [1:0] fmt);
        logic [7:0] hr;
        logic [7:0] mn;
        logic [7:0] sc;
        logic [7:0] hu;
        logic [7:0] hrMax;
        logic wrap;
        hr = v[31:24];
        mn = v[23:16];
        sc = v[15:8];
        hu = v[7:0];
        hrMax = (fmt == 2'(gp_timer_pkg::FMT_DAY)) ? `HOUR_DAY : `HOUR_LONG;
        wrap = 1'b0;
        if (fmt != 2'(gp_timer_pkg::FMT_DAY)
            && fmt != 2'(gp_timer_pkg::FMT_LONG))
        begin
            if (up)
            begin
                wrap = (v == 32'hFFFFFFFF);
                v = v + 32'h00000001;
            end
            else
            begin
                wrap = (v == 32'h00000000);
                v = v - 32'h00000001;
            end
            stepFn = {wrap, v};
        end
        else if (up)
        begin
            if (hu < `HUND_MAX) hu = hu + 8'h01;
            else
            begin
                hu = 8'h00;
                if (sc < `SEXA_MAX) sc = sc + 8'h01;
                else
                begin
                    sc = 8'h00;
                    if (mn < `SEXA_MAX) mn = mn + 8'h01;
                    else
                    begin
                        mn = 8'h00;
                        if (hr < hrMax) hr = hr + 8'h01;
                        else
                        begin
                            hr = 8'h00;
                            wrap = 1'b1;
                        end
                    end
                end
            end
            stepFn = {wrap, hr, mn, sc, hu};
        end
        else
        begin
            if (hu != 8'h00 && hu <= `HUND_MAX) hu = hu - 8'h01;
            else
            begin
                hu = `HUND_MAX;
                if (sc != 8'h00 && sc <= `SEXA_MAX) sc = sc - 8'h01;
                else
                begin
                    sc = `SEXA_MAX;
                    if (mn != 8'h00 && mn <= `SEXA_MAX) mn = mn - 8'h01;
                    else
                    begin
                        mn = `SEXA_MAX;
                        if (hr != 8'h00 && hr <= hrMax) hr = hr - 8'h01;
                        else
                        begin
                            hr = hrMax;
                            wrap = 1'b1;
                        end
                    end
                end
            end
            stepFn = {wrap, hr, mn, sc, hu};
        end
    endfunction

    assign stepVal = stepFn(count_ff, ctrl_ff[`BIT_UP], fmtSel);
    assign wrapEvt = preTick && stepVal[32];

    // counter: clear write reloads first, then wrap, then step
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_ff <= `RST_WORD;
        end
        else if (wrClear)
        begin
            count_ff <= reload_ff;
        end
        else if (wrapEvt && ctrl_ff[`BIT_PERIODIC])
        begin
            count_ff <= reload_ff;
        end
        else if (preTick)
        begin
            count_ff <= stepVal[31:0];
        end
    end

    // load register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reload_ff <= `RST_WORD;
        end
        else if (wrReload)
        begin
            reload_ff <= wrData;
        end
    end

    // control register; postscaler field guarded by its write enable
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= `RST_WORD;
        end
        else
        begin
            if (wrCtrl)
            begin
                ctrl_ff[`BIT_IRQ_SEL:0] <= wrData[`BIT_IRQ_SEL:0];
                if (wrData[`BIT_POST_WE])
                begin
                    ctrl_ff[`POST_HI:`POST_LO] <= wrData[`POST_HI:`POST_LO];
                end
            end
            // compare flag: set wins over clear write
            if (postHit)
            begin
                ctrl_ff[`BIT_POST_HIT] <= 1'b1;
            end
            else if (wrClear)
            begin
                ctrl_ff[`BIT_POST_HIT] <= 1'b0;
            end
        end
    end

    // postscaler: counts wraps, hits when it reaches the programmed value
    assign postHit = wrapEvt && (postCnt_ff == ctrl_ff[`POST_HI:`POST_LO]);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            postCnt_ff <= 8'h00;
        end
        else if (postHit || wrClear)
        begin
            postCnt_ff <= 8'h00;
        end
        else if (wrapEvt)
        begin
            postCnt_ff <= postCnt_ff + 8'h01;
        end
    end

    // capture on first assertion of the selected event
    assign evtRise = irqSource & ~evtPrev_ff;
    assign capRise = ctrl_ff[`BIT_CAP_EN] && 6'(evtSel) < 6'(NUM_EVT)
        && evtRise[evtSel];
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evtPrev_ff <= '0;
            capture_ff <= `RST_WORD;
        end
        else
        begin
            evtPrev_ff <= irqSource;
            if (capRise)
            begin
                capture_ff <= count_ff;
            end
        end
    end

    // sticky status: timeout clears on clear write, others on read
    assign statSet[`STAT_TIMEOUT] = ctrl_ff[`BIT_IRQ_SEL] ? postHit : wrapEvt;
    assign statSet[`STAT_CAPTURE] = capRise;
    assign statSet[`STAT_POST] = postHit;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_ff <= '0;
        end
        else
        begin
            if (statSet[`STAT_TIMEOUT])
            begin
                status_ff[`STAT_TIMEOUT] <= 1'b1;
            end
            else if (wrClear)
            begin
                status_ff[`STAT_TIMEOUT] <= 1'b0;
            end
            for (int i = 1; i < `STAT_W; i++)
            begin
                if (statSet[i])
                begin
                    status_ff[i] <= 1'b1;
                end
                else if (rdStatus)
                begin
                    status_ff[i] <= 1'b0;
                end
            end
        end
    end

    // mask register and interrupt output
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            if (wrMask)
            begin
                mask_ff <= wrData[`STAT_W-1:0];
            end
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdData_ff <= `RST_WORD;
        end
        else if (rdEn)
        begin
            case (addr)
                `ADDR_RELOAD: rdData_ff <= reload_ff;
                `ADDR_COUNT: rdData_ff <= count_ff;
                `ADDR_CONTROL: rdData_ff <= ctrl_ff & `CTRL_WR_MASK
                    | (32'(ctrl_ff[`BIT_POST_HIT]) << `BIT_POST_HIT);
                `ADDR_CAPTURE: rdData_ff <= capture_ff;
                `ADDR_STATUS: rdData_ff <= 32'(status_ff);
                `ADDR_MASK: rdData_ff <= 32'(mask_ff);
                default: rdData_ff <= `RST_WORD;
            endcase
        end
        else
        begin
            rdData_ff <= `RST_WORD;
        end
    end

    // checks
    sequence clrWrite;
        wrClear;
    endsequence
    sequence reloadSeen;
        count_ff == $past(reload_ff);
    endsequence

    a_clear_reload: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clrWrite |=> reloadSeen)
        else $error("clear write did not reload counter");
    a_wrap_reload: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wrapEvt && ctrl_ff[`BIT_PERIODIC] |=> reloadSeen)
        else $error("periodic wrap did not reload");
    a_disabled_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ctrl_ff[`BIT_ENABLE] && !wrClear |=> $stable(count_ff))
        else $error("disabled timer moved");
    a_capture_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
        capRise |=> capture_ff == $past(count_ff))
        else $error("capture lost count value");
    a_capture_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ctrl_ff[`BIT_CAP_EN] |=> $stable(capture_ff))
        else $error("capture while disabled");
    a_irq_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        status_ff[`STAT_TIMEOUT] && !wrClear |=>
        status_ff[`STAT_TIMEOUT])
        else $error("timeout flag dropped without clear");
    a_post_guard: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wrCtrl && !wrData[`BIT_POST_WE] |=>
        $stable(ctrl_ff[`POST_HI:`POST_LO]))
        else $error("postscaler changed without enable");
    a_div_sixteen: assert property (@(posedge clk_sys) disable iff (!rst_b)
        preTick && ctrl_ff[`PRE_HI:`PRE_LO] == `PRE_DIV16 |->
        presCnt_ff[3:0] == 4'hF)
        else $error("divide by 16 ticked early");
    a_low_power: assert property (@(posedge clk_sys) disable iff (!rst_b)
        lowPower && srcSel == 3'(gp_timer_pkg::SRC_CORE) |-> !srcTick)
        else $error("core clock ticked in low power");
    a_count_up: assert property (@(posedge clk_sys) disable iff (!rst_b)
        preTick && !wrClear && ctrl_ff[`BIT_UP] && fmtSel == 2'h0
        && !stepVal[32] |=> count_ff == $past(count_ff) + 32'h1)
        else $error("up count step wrong");
    a_hund_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fmtSel[1] && count_ff[7:0] <= `HUND_MAX && !wrClear && !wrapEvt
        |=> count_ff[7:0] <= `HUND_MAX)
        else $error("hundredths out of range");

endmodule
`default_nettype wire

// ### design/gp_timer_consts.svh
/*
 * Offsets, field positions and reset values of the general purpose timer.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
// Summary of operation
// - a 32-bit counter counts up or down as control selects.
// - prescale codes 0000, 0100, 1000, 1111 divide by 1, 16, 256, 32768.
// - source field 11:9 picks oscillator, core, peripheral clock or pin.
// - format field 5:4 picks binary, 23-hour or 255-hour time format.
// - first assertion of chosen source copies count; counting continues.
// - capture only while bit 17 set; bits 16:12 pick source 0 to 16.
// - in periodic mode a wrap reloads the counter from the load register.
// - any write to clear register drops timeout flag and reloads at once.
// - control bit 7 enables counting; timer is off after reset.
// - control bit 6 selects periodic, else free-running, the default.
// - control bit 8 counts up when set, down when clear, the default.
// - postscaler bits 31:24 change only with bit 23 in same write.
// - bit 19 is postscaler compare flag, bit 18 interrupt selection.
// - in low power, pin or oscillator sourced timer keeps counting.
`ifndef GP_TIMER_CONSTS_SVH
`define GP_TIMER_CONSTS_SVH

`define ADDR_RELOAD 32'hFFFF0320
`define ADDR_COUNT 32'hFFFF0324
`define ADDR_CONTROL 32'hFFFF0328
`define ADDR_CLEAR 32'hFFFF032C
`define ADDR_CAPTURE 32'hFFFF0330
`define ADDR_STATUS 32'hFFFF0334
`define ADDR_MASK 32'hFFFF0338

`define RST_WORD 32'h00000000
`define CTRL_WR_MASK 32'hFF07FFFF

`define BIT_POST_WE 23
`define BIT_POST_HIT 19
`define BIT_IRQ_SEL 18
`define BIT_CAP_EN 17
`define BIT_UP 8
`define BIT_ENABLE 7
`define BIT_PERIODIC 6
`define POST_HI 31
`define POST_LO 24
`define EVT_HI 16
`define EVT_LO 12
`define SRC_HI 11
`define SRC_LO 9
`define FMT_HI 5
`define FMT_LO 4
`define PRE_HI 3
`define PRE_LO 0

`define PRE_DIV16 4'h4
`define PRE_DIV256 4'h8
`define PRE_DIV32K 4'hF
`define MASK_DIV16 15'h000F
`define MASK_DIV256 15'h00FF
`define MASK_DIV32K 15'h7FFF

`define HUND_MAX 8'h63
`define SEXA_MAX 8'h3B
`define HOUR_DAY 8'h17
`define HOUR_LONG 8'hFF

`define STAT_TIMEOUT 0
`define STAT_CAPTURE 1
`define STAT_POST 2
`define STAT_W 3

`endif

// ### design/gp_timer_pkg.sv
/*
 * Types shared by the general purpose timer.
 * Assumes the constants header is included where numbers are needed.
 */
package gp_timer_pkg;
    typedef logic [31:0] word_type;
    typedef enum logic [1:0] {FMT_BIN, FMT_RSV, FMT_DAY, FMT_LONG} format_type;
    typedef enum logic [2:0] {SRC_OSC, SRC_CORE, SRC_PERIPH, SRC_PIN,
                              SRC_NONE4, SRC_NONE5, SRC_NONE6, SRC_NONE7}
        source_type;
endpackage

// ### tb/tb_top.sv
/*
 * Self-checking testbench for the general purpose timer: register port,
 * counting, prescaler, time formats, capture, postscaler and interrupt.
 * Assumes the timer files and the constants header are compiled with it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gp_timer_consts.svh"

module tb_top;
    logic clk_sys;
    logic rst_b;
    logic [31:0] addr;
    logic [31:0] wrData;
    logic wrEn;
    logic rdEn;
    logic [31:0] rdData_ff;
    logic [3:0] srcLvl;
    logic lowPower;
    logic [16:0] irqSrc;
    logic irq_ff;
    int n_errors;
    int comparisons;

    // device under test with default counter width and event count
    gp_timer dut_u (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .addr(addr),
        .wrData(wrData),
        .wrEn(wrEn),
        .rdEn(rdEn),
        .rdData_ff(rdData_ff),
        .oscClk(srcLvl[0]),
        .coreClk(srcLvl[1]),
        .periphClk(srcLvl[2]),
        .generalInputPin(srcLvl[3]),
        .lowPower(lowPower),
        .irqSource(irqSrc),
        .irq_ff(irq_ff)
    );

    // 250 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // verdict and end of run
    task results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // compare one value, four-state exact
    task chk(input gp_timer_pkg::word_type got,
             input gp_timer_pkg::word_type exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk_sys);
        wrEn <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk_sys);
        rdEn <= 1'b0;
        #1;
        d = rdData_ff;
    endtask

    task rdChk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // n rising edges on source level s, then let the step land
    task tick(input int s, input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            srcLvl[s] <= 1'b1;
            @(posedge clk_sys);
            srcLvl[s] <= 1'b0;
        end
        repeat (3) @(posedge clk_sys);
    endtask

    // set reload value and force it into the counter
    task load(input logic [31:0] v);
        wr(`ADDR_RELOAD, v);
        wr(`ADDR_CLEAR, 32'h000000A5);
    endtask

    function automatic logic [31:0] upSrc(input logic [2:0] s);
        return {20'h00000, s, 9'h180};
    endfunction

    // reset values, read-only and unmapped places
    task test_reset();
        chk({31'h0, irq_ff}, 32'h00000000);
        rdChk(`ADDR_CONTROL, 32'h00000000);
        rdChk(`ADDR_RELOAD, 32'h00000000);
        rdChk(`ADDR_COUNT, 32'h00000000);
        rdChk(`ADDR_CAPTURE, 32'h00000000);
        rdChk(`ADDR_MASK, 32'h00000000);
        wr(`ADDR_COUNT, 32'h00001234);
        wr(32'hFFFF033C, 32'h00005678);
        rdChk(`ADDR_COUNT, 32'h00000000);
        rdChk(32'hFFFF033C, 32'h00000000);
        wr(`ADDR_RELOAD, 32'hA5A5A5A5);
        rdChk(`ADDR_RELOAD, 32'hA5A5A5A5);
        tick(0, 2);
        rdChk(`ADDR_COUNT, 32'h00000000);
    endtask

    // down counting by default, clear write reloads at once
    task test_down();
        load(32'h00000005);
        rdChk(`ADDR_COUNT, 32'h00000005);
        wr(`ADDR_CONTROL, 32'h00000080);
        tick(0, 3);
        rdChk(`ADDR_COUNT, 32'h00000002);
        wr(`ADDR_CONTROL, 32'h00000000);
        tick(0, 2);
        rdChk(`ADDR_COUNT, 32'h00000002);
    endtask

    // each clock source counts up, the next source ignored
    task test_sources();
        for (int s = 0; s < 4; s++)
        begin
            load(32'h00000010);
            wr(`ADDR_CONTROL, upSrc(3'(s)));
            tick((s + 1) % 4, 2);
            tick(s, 2);
            rdChk(`ADDR_COUNT, 32'h00000012);
        end
    endtask

    // low power stops the core source, the pin keeps counting
    task test_lowpower();
        @(posedge clk_sys);
        lowPower <= 1'b1;
        load(32'h00000000);
        wr(`ADDR_CONTROL, upSrc(3'h1));
        tick(1, 2);
        rdChk(`ADDR_COUNT, 32'h00000000);
        wr(`ADDR_CONTROL, upSrc(3'h3));
        tick(3, 2);
        rdChk(`ADDR_COUNT, 32'h00000002);
        @(posedge clk_sys);
        lowPower <= 1'b0;
    endtask

    // divide codes 0100, 1000, 1111: one short of the count, then the step
    task test_prescale();
        logic [3:0] preCode[3];
        int preDiv[3];
        preCode = '{4'h4, 4'h8, 4'hF};
        preDiv = '{16, 256, 32768};
        for (int i = 0; i < 3; i++)
        begin
            load(32'h00000000);
            wr(`ADDR_CONTROL, {28'h0000018, preCode[i]});
            tick(0, preDiv[i] - 1);
            rdChk(`ADDR_COUNT, 32'h00000000);
            tick(0, 1);
            rdChk(`ADDR_COUNT, 32'h00000001);
        end
    endtask

    // periodic reload, free-running wrap, interrupt mask and clear
    task test_wrap_irq();
        load(32'h00000000);
        wr(`ADDR_RELOAD, 32'h00000007);
        wr(`ADDR_MASK, 32'h00000001);
        wr(`ADDR_CONTROL, 32'h000000C0);
        tick(0, 1);
        rdChk(`ADDR_COUNT, 32'h00000007);
        chk({31'h0, irq_ff}, 32'h00000001);
        rdChk(`ADDR_STATUS, 32'h00000005);
        rdChk(`ADDR_STATUS, 32'h00000001);
        wr(`ADDR_MASK, 32'h00000000);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq_ff}, 32'h00000000);
        wr(`ADDR_MASK, 32'h00000001);
        tick(0, 2);
        chk({31'h0, irq_ff}, 32'h00000001);
        wr(`ADDR_CLEAR, 32'h00000000);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq_ff}, 32'h00000000);
        rdChk(`ADDR_COUNT, 32'h00000007);
        wr(`ADDR_CONTROL, 32'h00000080);
        load(32'h00000000);
        tick(0, 1);
        rdChk(`ADDR_COUNT, 32'hFFFFFFFF);
        wr(`ADDR_CONTROL, 32'h00000180);
        tick(0, 1);
        rdChk(`ADDR_COUNT, 32'h00000000);
        wr(`ADDR_CLEAR, 32'h00000000);
        wr(`ADDR_MASK, 32'h00000000);
    endtask

    // time formats: field carries and hour limits
    task test_format();
        wr(`ADDR_CONTROL, 32'h000001A0);
        load(32'h173B3B63);
        tick(0, 1);
        rdChk(`ADDR_COUNT, 32'h00000000);
        load(32'h00003B63);
        tick(0, 1);
        rdChk(`ADDR_COUNT, 32'h00010000);
        wr(`ADDR_CONTROL, 32'h000000B0);
        load(32'h00000000);
        tick(0, 1);
        rdChk(`ADDR_COUNT, 32'hFF3B3B63);
        wr(`ADDR_CLEAR, 32'h00000000);
    endtask

    // capture on chosen event while counting goes on
    task test_capture();
        rdChk(`ADDR_STATUS, 32'h00000004);
        load(32'h00000055);
        wr(`ADDR_CONTROL, 32'h00025080);
        irqSrc[5] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tick(0, 1);
        rdChk(`ADDR_CAPTURE, 32'h00000055);
        rdChk(`ADDR_COUNT, 32'h00000054);
        rdChk(`ADDR_STATUS, 32'h00000002);
        @(posedge clk_sys);
        irqSrc[5] <= 1'b0;
        wr(`ADDR_CONTROL, 32'h00005080);
        irqSrc[5] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdChk(`ADDR_CAPTURE, 32'h00000055);
        @(posedge clk_sys);
        irqSrc[5] <= 1'b0;
    endtask

    // postscaler write enable, reserved bits, compare flag
    task test_postscale();
        wr(`ADDR_CONTROL, 32'h02700080);
        rdChk(`ADDR_CONTROL, 32'h00000080);
        load(32'h00000000);
        wr(`ADDR_CONTROL, 32'h018000C0);
        rdChk(`ADDR_CONTROL, 32'h010000C0);
        tick(0, 3);
        rdChk(`ADDR_CONTROL, 32'h010800C0);
        rdChk(`ADDR_STATUS, 32'h00000005);
        // interrupt selection: timeout only on postscaler hit
        wr(`ADDR_CLEAR, 32'h00000000);
        wr(`ADDR_CONTROL, 32'h004400C0);
        rdChk(`ADDR_CONTROL, 32'h010400C0);
        tick(0, 1);
        rdChk(`ADDR_STATUS, 32'h00000000);
        tick(0, 1);
        rdChk(`ADDR_STATUS, 32'h00000005);
        wr(`ADDR_CONTROL, 32'h00000000);
        wr(`ADDR_CLEAR, 32'h00000000);
        rdChk(`ADDR_CONTROL, 32'h01000000);
    endtask

    // hang guard, about 90k cycles against some 66.5k needed
    initial
    begin
        #360000;
        n_errors++;
        results();
    end

    // main sequence
    initial
    begin
        n_errors = 0;
        comparisons = 0;
        rst_b = 1'b0;
        addr = 32'h00000000;
        wrData = 32'h00000000;
        wrEn = 1'b0;
        rdEn = 1'b0;
        srcLvl = 4'h0;
        lowPower = 1'b0;
        irqSrc = 17'h00000;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_reset();
        test_down();
        test_sources();
        test_lowpower();
        test_prescale();
        test_wrap_irq();
        test_format();
        test_capture();
        test_postscale();
        results();
    end
endmodule

`default_nettype wire
